// file: hw/gtpc_timer.sv
// gated timer pulse capture: 16-bit gated timer with single-pulse capture
`timescale 1ns/100ps
module gtpc_timer #(
  parameter int WIDTH = 16
) (
  // clock, reset, enable
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             clk_en_in,
  // register port
  input  wire logic [3:0]       addr_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [7:0]       rdata_out,
  // gate sources and external count clock (asynchronous pins)
  input  wire logic             gate_input_pin_in,
  input  wire logic             comp1_in,
  input  wire logic             comp2_in,
  input  wire logic             ext_clk_in,
  // period timer match pulse (same clock)
  input  wire logic             period_match_in,
  // compare unit
  input  wire logic [3:0]       compare_mode_field_in,
  input  wire logic             compare_unit_two_in,
  input  wire logic             adc_enabled_in,
  // status outputs
  output logic                  overflow_irq_out,
  output logic                  gate_irq_out,
  output logic                  adc_start_out,
  output logic      [WIDTH-1:0] count_out
);

  typedef enum logic [1:0] {GTPC_IDLE, GTPC_ARMED, GTPC_CAPTURE} gtpc_pulse_e;

  // agreed levels of the four asynchronous pins
  logic [3:0] pin_raw, pin_agreed;
  logic       pin_lvl, c1_lvl, c2_lvl, ext_lvl;

  // registers
  logic [7:0]       gate_control, control, flags, enables;
  logic [WIDTH-1:0] count, compare_value;
  logic [7:0]       next_gate_control, next_control, next_flags, next_enables;
  logic [WIDTH-1:0] next_count, next_compare_value;
  logic             toggle_ff, next_toggle_ff;
  logic             src_prev, next_src_prev;
  logic             level_prev, next_level_prev;
  logic             pre_prev, next_pre_prev;
  logic             ext_prev, next_ext_prev;
  logic [1:0]       div, next_div;
  gtpc_pulse_e      pulse_st, next_pulse_st;
  logic [7:0]       next_rdata;
  logic             next_adc_start;

  // combinational helpers
  logic src_raw, src_gate, gate_lvl, tick, trig, wr_count;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
    hit = wr_in && (a == ref_a);
  endfunction

  // one count step: running, on a tick, and inside the gate window if gated
  function automatic logic count_step(input logic on, input logic t,
                                      input logic gate_en, input logic win);
    count_step = on && t && (!gate_en || win);
  endfunction

  // pin order: gate pin, comparator 1, comparator 2, external count clock
  assign pin_raw = {ext_clk_in, comp2_in, comp1_in, gate_input_pin_in};

  for (genvar gi = 0; gi < 4; gi++) begin : g_sync
    logic [2:0] stage;
    logic       agreed;
    logic       next_agreed;
    // a level is taken only once the last two stages agree, so a
    // metastable first stage never reaches the gate logic
    always_comb begin
      next_agreed = (stage[1] == stage[2]) ? stage[2] : agreed;
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        stage  <= 3'h0;
        agreed <= 1'b0;
      end else if (clk_en_in) begin
        stage  <= {stage[1:0], pin_raw[gi]};
        agreed <= next_agreed;
      end
    end

    assign pin_agreed[gi] = agreed;
  end

  assign pin_lvl = pin_agreed[0];
  assign c1_lvl  = pin_agreed[1];
  assign c2_lvl  = pin_agreed[2];
  assign ext_lvl = pin_agreed[3];

  // gate path: source select, toggle stage, single-pulse window
  always_comb begin
    case (gate_control[gtpc_pkg::GC_SRC_HI:gtpc_pkg::GC_SRC_LO])
      gtpc_pkg::SRC_PIN:    src_raw = pin_lvl;
      gtpc_pkg::SRC_PERIOD: src_raw = period_match_in;
      gtpc_pkg::SRC_COMP1:  src_raw = c1_lvl;
      default:              src_raw = c2_lvl;
    endcase
    // polarity applied so that "active" is high from here on
    src_gate = (src_raw == gate_control[gtpc_pkg::GC_POLARITY]);
    next_src_prev = src_gate;
    next_toggle_ff = toggle_ff;
    if (!gate_control[gtpc_pkg::GC_TOGGLE]) begin
      next_toggle_ff = 1'b0;
    end else if (src_gate && !src_prev) begin
      next_toggle_ff = !toggle_ff;
    end
    // toggled signal feeds single-pulse logic when both are on
    gate_lvl = gate_control[gtpc_pkg::GC_TOGGLE] ? toggle_ff : src_gate;
    // edge seen before the window, so a gate already high when armed waits
    next_pre_prev = gate_lvl;
    next_pulse_st = pulse_st;
    if (!gate_control[gtpc_pkg::GC_SPM] || !gate_control[gtpc_pkg::GC_ARM]) begin
      next_pulse_st = GTPC_IDLE;
    end else begin
      case (pulse_st)
        GTPC_IDLE:    next_pulse_st = GTPC_ARMED;
        GTPC_ARMED:   if (gate_lvl && !pre_prev) next_pulse_st = GTPC_CAPTURE;
        GTPC_CAPTURE: if (!gate_lvl) next_pulse_st = GTPC_IDLE;
        default:      next_pulse_st = GTPC_IDLE;
      endcase
    end
    // in single-pulse mode only the captured pulse is a gate window
    if (gate_control[gtpc_pkg::GC_SPM]) begin
      gate_lvl = gate_lvl && (next_pulse_st == GTPC_CAPTURE);
    end
    next_level_prev = gate_lvl;
  end

  // timer clock select, including a quarter-rate instruction tick
  always_comb begin
    next_div = div + 2'h1;
    next_ext_prev = ext_lvl;
    case (control[gtpc_pkg::CT_CLK_HI:gtpc_pkg::CT_CLK_LO])
      gtpc_pkg::CLK_INSTR:  tick = (div == gtpc_pkg::INSTR_DIV_LAST);
      gtpc_pkg::CLK_SYSTEM: tick = 1'b1;
      default:              tick = ext_lvl && !ext_prev;
    endcase
  end

  // registers, counter and flags
  always_comb begin
    next_gate_control  = gate_control;
    next_control       = control;
    next_flags         = flags;
    next_enables       = enables;
    next_count         = count;
    next_compare_value = compare_value;
    wr_count = hit(addr_in, gtpc_pkg::ADDR_COUNT_LOW) || hit(addr_in, gtpc_pkg::ADDR_COUNT_HIGH);
    trig = (compare_mode_field_in == gtpc_pkg::COMPARE_SPECIAL) && count == compare_value;
    next_adc_start = trig && compare_unit_two_in && adc_enabled_in;
    if (count_step(control[gtpc_pkg::CT_ON], tick,
                   gate_control[gtpc_pkg::GC_COUNT_EN], gate_lvl)) begin
      next_count = count + 16'h0001;
      // a trigger reset is not an overflow, even at the top of the range
      if (count == gtpc_pkg::COUNT_MAX && !trig) begin
        next_flags[gtpc_pkg::FL_OVERFLOW] = 1'b1;
      end
    end
    if (trig) begin
      next_count = gtpc_pkg::RST_COUNT;
    end
    if (hit(addr_in, gtpc_pkg::ADDR_COUNT_LOW)) begin
      next_count[7:0] = wdata_in;
    end
    if (hit(addr_in, gtpc_pkg::ADDR_COUNT_HIGH)) begin
      next_count[15:8] = wdata_in;
    end
    if (wr_count && !hit(addr_in, gtpc_pkg::ADDR_COUNT_HIGH)) begin
      next_count[15:8] = count[15:8];
    end
    if (wr_count && !hit(addr_in, gtpc_pkg::ADDR_COUNT_LOW)) begin
      next_count[7:0] = count[7:0];
    end
    if (hit(addr_in, gtpc_pkg::ADDR_GATE_CONTROL)) begin
      next_gate_control = wdata_in;
    end
    if (!next_gate_control[gtpc_pkg::GC_SPM]) begin
      next_gate_control[gtpc_pkg::GC_ARM] = 1'b0;
    end else if (pulse_st == GTPC_CAPTURE && next_pulse_st == GTPC_IDLE) begin
      next_gate_control[gtpc_pkg::GC_ARM] = 1'b0;
    end
    next_gate_control[gtpc_pkg::GC_LEVEL] = gate_lvl;
    if (hit(addr_in, gtpc_pkg::ADDR_CONTROL)) begin
      next_control = wdata_in;
    end
    if (hit(addr_in, gtpc_pkg::ADDR_ENABLES)) begin
      next_enables = wdata_in & 8'h03;
    end
    if (hit(addr_in, gtpc_pkg::ADDR_COMPARE_LOW)) begin
      next_compare_value[7:0] = wdata_in;
    end
    if (hit(addr_in, gtpc_pkg::ADDR_COMPARE_HIGH)) begin
      next_compare_value[15:8] = wdata_in;
    end
    // write-one-to-clear; a set in the same cycle wins
    if (hit(addr_in, gtpc_pkg::ADDR_FLAGS)) begin
      next_flags = next_flags & ~wdata_in;
      if (count_step(control[gtpc_pkg::CT_ON], tick,
                     gate_control[gtpc_pkg::GC_COUNT_EN], gate_lvl) &&
          count == gtpc_pkg::COUNT_MAX && !trig) begin
        next_flags[gtpc_pkg::FL_OVERFLOW] = 1'b1;
      end
    end
    if (level_prev && !gate_lvl) begin
      next_flags[gtpc_pkg::FL_GATE] = 1'b1;
    end
    next_flags[7:2] = 6'h00;
  end

  // read port: data stand one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = gtpc_pkg::RST_BYTE;
    if (rd_in) begin
      case (addr_in)
        gtpc_pkg::ADDR_COUNT_LOW:    next_rdata = count[7:0];
        gtpc_pkg::ADDR_COUNT_HIGH:   next_rdata = count[15:8];
        gtpc_pkg::ADDR_GATE_CONTROL: next_rdata = gate_control;
        gtpc_pkg::ADDR_CONTROL:      next_rdata = control;
        gtpc_pkg::ADDR_FLAGS:        next_rdata = flags;
        gtpc_pkg::ADDR_ENABLES:      next_rdata = enables;
        gtpc_pkg::ADDR_COMPARE_LOW:  next_rdata = compare_value[7:0];
        gtpc_pkg::ADDR_COMPARE_HIGH: next_rdata = compare_value[15:8];
        default:                     next_rdata = gtpc_pkg::RST_BYTE;
      endcase
    end
  end

  // gate path state
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      toggle_ff  <= 1'b0;
      src_prev   <= 1'b0;
      level_prev <= 1'b0;
      pre_prev   <= 1'b0;
      pulse_st   <= GTPC_IDLE;
    end else if (clk_en_in) begin
      toggle_ff  <= next_toggle_ff;
      src_prev   <= next_src_prev;
      level_prev <= next_level_prev;
      pre_prev   <= next_pre_prev;
      pulse_st   <= next_pulse_st;
    end
  end

  // timer clock state; the divider runs free, so the first instruction
  // tick after switching on may come up to three cycles late
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_prev <= 1'b0;
      div      <= 2'h0;
    end else if (clk_en_in) begin
      ext_prev <= next_ext_prev;
      div      <= next_div;
    end
  end

  // software-visible registers
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_control  <= gtpc_pkg::RST_BYTE;
      control       <= gtpc_pkg::RST_BYTE;
      flags         <= gtpc_pkg::RST_BYTE;
      enables       <= gtpc_pkg::RST_BYTE;
      count         <= gtpc_pkg::RST_COUNT;
      compare_value <= gtpc_pkg::RST_COUNT;
    end else if (clk_en_in) begin
      gate_control  <= next_gate_control;
      control       <= next_control;
      flags         <= next_flags;
      enables       <= next_enables;
      count         <= next_count;
      compare_value <= next_compare_value;
    end
  end

  // outputs, each straight from a flip-flop
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out        <= gtpc_pkg::RST_BYTE;
      adc_start_out    <= 1'b0;
      overflow_irq_out <= 1'b0;
      gate_irq_out     <= 1'b0;
      count_out        <= gtpc_pkg::RST_COUNT;
    end else if (clk_en_in) begin
      rdata_out        <= next_rdata;
      adc_start_out    <= next_adc_start;
      overflow_irq_out <= next_flags[gtpc_pkg::FL_OVERFLOW] &&
                          next_enables[gtpc_pkg::FL_OVERFLOW];
      gate_irq_out     <= next_flags[gtpc_pkg::FL_GATE] &&
                          next_enables[gtpc_pkg::FL_GATE];
      count_out        <= next_count;
    end
  end

endmodule

// file: common/gtpc_pkg.sv
// gated timer pulse capture: shared constants
package gtpc_pkg;
  // register indices on the plain port (address in 8-bit units)
  localparam logic [3:0] ADDR_COUNT_LOW    = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h1;
  localparam logic [3:0] ADDR_GATE_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_CONTROL      = 4'h3;
  localparam logic [3:0] ADDR_FLAGS        = 4'h4;
  localparam logic [3:0] ADDR_ENABLES      = 4'h5;
  localparam logic [3:0] ADDR_COMPARE_LOW  = 4'h6;
  localparam logic [3:0] ADDR_COMPARE_HIGH = 4'h7;
  // gate control fields
  localparam int GC_COUNT_EN  = 7;
  localparam int GC_POLARITY  = 6;
  localparam int GC_TOGGLE    = 5;
  localparam int GC_SPM       = 4;
  localparam int GC_ARM       = 3;
  localparam int GC_LEVEL     = 2;
  localparam int GC_SRC_HI    = 1;
  localparam int GC_SRC_LO    = 0;
  // control fields
  localparam int CT_CLK_HI    = 7;
  localparam int CT_CLK_LO    = 6;
  localparam int CT_ON        = 0;
  // flag and enable fields
  localparam int FL_OVERFLOW  = 1;
  localparam int FL_GATE      = 0;
  // compare unit mode code for special event trigger
  localparam logic [3:0] COMPARE_SPECIAL = 4'hB;
  // clock select codes
  localparam logic [1:0] CLK_INSTR  = 2'h0;
  localparam logic [1:0] CLK_SYSTEM = 2'h1;
  // gate source codes
  localparam logic [1:0] SRC_PIN    = 2'h0;
  localparam logic [1:0] SRC_PERIOD = 2'h1;
  localparam logic [1:0] SRC_COMP1  = 2'h2;
  // reset values and the top of the count range
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // instruction clock is a quarter of the system clock
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

// file: verification/gtpc_period_model.sv
// gtpc partner: period timer whose reset pulse feeds the period gate source
`timescale 1ns/100ps
module gtpc_period_model #(
  parameter int PERIOD = 5
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  // run control and match pulse
  input  wire logic run_in,
  output logic      match_pulse_out
);
  logic [7:0] tick;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick            <= 8'h00;
      match_pulse_out <= 1'b0;
    end else begin
      // one high cycle as the timer drops back to zero after its match
      match_pulse_out <= run_in && tick == PERIOD[7:0];
      tick            <= (!run_in || tick == PERIOD[7:0]) ? 8'h00 : tick + 8'h01;
    end
  end
endmodule

// file: verification/gtpc_checker.sv
// gtpc checker: concurrent checks on the timer ports
`timescale 1ns/100ps
module gtpc_checker #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic             ref_clk_in,
  input wire logic             nrst_in,
  input wire logic             clk_en_in,
  // register port
  input wire logic [3:0]       addr_in,
  input wire logic [7:0]       wdata_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire logic [7:0]       rdata_out,
  // compare unit
  input wire logic [3:0]       compare_mode_field_in,
  input wire logic             compare_unit_two_in,
  input wire logic             adc_enabled_in,
  // status
  input wire logic             overflow_irq_out,
  input wire logic             gate_irq_out,
  input wire logic             adc_start_out,
  input wire logic [WIDTH-1:0] count_out
);
  // shadow of the enables, since the checker only sees the ports
  logic [1:0] en_q;
  logic [1:0] next_en_q;
  logic       drop_ovf;
  logic       trig_ok;
  always_comb begin
    next_en_q = en_q;
    if (wr_in && clk_en_in && addr_in == gtpc_pkg::ADDR_ENABLES) begin
      next_en_q = wdata_in[1:0];
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_q <= 2'h0;
    end else begin
      en_q <= next_en_q;
    end
  end
  assign drop_ovf = wr_in && ((addr_in == gtpc_pkg::ADDR_FLAGS && wdata_in[1])
                    || (addr_in == gtpc_pkg::ADDR_ENABLES && !wdata_in[1]));
  assign trig_ok = compare_unit_two_in && adc_enabled_in
                   && compare_mode_field_in == gtpc_pkg::COMPARE_SPECIAL;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_top;
    count_out == '1 ##1 count_out != '1;
  endsequence
  sequence s_wrapped;
    $past(count_out) == '1 && count_out == '0 && en_q[1];
  endsequence
  a_read_idle: assert property (clk_en_in && !rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside read cycle");
  a_count_wrap: assert property (s_top |-> count_out == '0)
    else $error("count left all ones without wrapping to zero");
  a_ovf_raise: assert property (s_wrapped |-> ##[0:2] overflow_irq_out)
    else $error("wrap gave no overflow request");
  a_ovf_masked: assert property (!en_q[1] [*3] |-> !overflow_irq_out)
    else $error("overflow request while disabled");
  a_gate_masked: assert property (!en_q[0] [*3] |-> !gate_irq_out)
    else $error("gate request while disabled");
  a_ovf_sticky: assert property ($fell(overflow_irq_out) |->
    $past(drop_ovf) || $past(drop_ovf, 2) || $past(drop_ovf, 3))
    else $error("overflow request dropped without software");
  a_adc_cause: assert property (adc_start_out |-> $past(trig_ok) || $past(trig_ok, 2))
    else $error("conversion start without enabled unit two trigger");
  a_adc_single: assert property (adc_start_out |=> !adc_start_out)
    else $error("conversion start longer than one cycle");
  a_trig_clear: assert property (adc_start_out |-> ##[0:2] count_out == '0)
    else $error("trigger did not clear the count");
endmodule
bind gtpc_timer gtpc_checker #(.WIDTH(WIDTH)) u_chk (.ref_clk_in, .nrst_in, .clk_en_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .compare_mode_field_in,
  .compare_unit_two_in, .adc_enabled_in, .overflow_irq_out, .gate_irq_out,
  .adc_start_out, .count_out);

// file: verification/gtpc_timer_tb.sv
// gtpc testbench: register-driven scenarios for the gated timer
`timescale 1ns/100ps
module gtpc_timer_tb;
  logic        ref_clk_in, nrst_in, clk_en_in, wr_in, rd_in, run_period;
  logic        gate_input_pin_in, comp1_in, comp2_in, ext_clk_in, period_match_in;
  logic        compare_unit_two_in, adc_enabled_in;
  logic        overflow_irq_out, gate_irq_out, adc_start_out;
  logic [3:0]  addr_in, compare_mode_field_in;
  logic [7:0]  wdata_in, rdata_out, d;
  logic [15:0] count_out, c1;
  int          mismatches, checks_done, n;
  gtpc_timer u_dut (.ref_clk_in, .nrst_in, .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .gate_input_pin_in, .comp1_in, .comp2_in, .ext_clk_in, .period_match_in,
    .compare_mode_field_in, .compare_unit_two_in, .adc_enabled_in, .overflow_irq_out,
    .gate_irq_out, .adc_start_out, .count_out);
  gtpc_period_model u_period (.ref_clk_in, .nrst_in, .run_in(run_period),
    .match_pulse_out(period_match_in));
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
    // end mid-cycle so that outputs read next are settled
    @(negedge ref_clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata_out;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic src(input int s, input logic v);
    @(posedge ref_clk_in);
    gate_input_pin_in <= v && s == 0;
    comp1_in <= v && s == 2;
    comp2_in <= v && s == 3;
  endtask
  task automatic pulse;
    src(0, 1'b1);
    cyc(10);
    src(0, 1'b0);
    cyc(8);
  endtask
  task automatic wait_adc;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (!adc_start_out && n < 100);
  endtask
  task automatic t_reset;
    rd(gtpc_pkg::ADDR_CONTROL);
    chk({8'h00, d}, 16'h0000);
    rd(gtpc_pkg::ADDR_FLAGS);
    chk({8'h00, d}, 16'h0000);
    rd(4'hF);
    chk({8'h00, d}, 16'h0000);
  endtask
  task automatic t_wrap;
    wr(gtpc_pkg::ADDR_ENABLES, 8'h02);
    wr(gtpc_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr(gtpc_pkg::ADDR_COUNT_LOW, 8'hF0);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h41);
    cyc(30);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h00);
    @(negedge ref_clk_in);
    chk(count_out, 16'h0010);
    chk1(overflow_irq_out, 1'b1);
    wr(gtpc_pkg::ADDR_ENABLES, 8'h00);
    cyc(3);
    chk1(overflow_irq_out, 1'b0);
    wr(gtpc_pkg::ADDR_ENABLES, 8'h02);
    cyc(3);
    chk1(overflow_irq_out, 1'b1);
    wr(gtpc_pkg::ADDR_FLAGS, 8'h02);
    cyc(3);
    chk1(overflow_irq_out, 1'b0);
  endtask
  task automatic t_clk;
    wr(gtpc_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(gtpc_pkg::ADDR_COUNT_HIGH, 8'h00);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h01);
    cyc(30);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h00);
    @(negedge ref_clk_in);
    chk(count_out, 16'h0008);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h81);
    repeat (5) begin
      @(posedge ref_clk_in);
      ext_clk_in <= 1'b1;
      cyc(6);
      @(posedge ref_clk_in);
      ext_clk_in <= 1'b0;
      cyc(6);
    end
    wr(gtpc_pkg::ADDR_CONTROL, 8'h00);
    @(negedge ref_clk_in);
    chk(count_out, 16'h000D);
  endtask
  task automatic t_gate;
    wr(gtpc_pkg::ADDR_ENABLES, 8'h01);
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'h40 | 8'(s));
        src(s, 1'b1);
        cyc(8);
        rd(gtpc_pkg::ADDR_GATE_CONTROL);
        chk1(d[2], 1'b1);
        wr(gtpc_pkg::ADDR_FLAGS, 8'h01);
        src(s, 1'b0);
        cyc(8);
        rd(gtpc_pkg::ADDR_GATE_CONTROL);
        chk1(d[2], 1'b0);
        rd(gtpc_pkg::ADDR_FLAGS);
        chk1(d[0], 1'b1);
        chk1(gate_irq_out, 1'b1);
      end
    end
    wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'h41);
    wr(gtpc_pkg::ADDR_FLAGS, 8'h01);
    run_period <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    run_period <= 1'b0;
    rd(gtpc_pkg::ADDR_FLAGS);
    chk1(d[0], 1'b1);
  endtask
  task automatic t_pulse;
    wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'hD0);
    wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'hD8);
    wr(gtpc_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(gtpc_pkg::ADDR_COUNT_HIGH, 8'h00);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h41);
    cyc(10);
    chk(count_out, 16'h0000);
    pulse;
    rd(gtpc_pkg::ADDR_GATE_CONTROL);
    chk1(d[3], 1'b0);
    c1 = count_out;
    chk1(c1 != 16'h0000, 1'b1);
    pulse;
    chk(count_out, c1);
    wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'hF0);
    wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'hF8);
    pulse;
    rd(gtpc_pkg::ADDR_GATE_CONTROL);
    chk1(d[3], 1'b1);
    pulse;
    rd(gtpc_pkg::ADDR_GATE_CONTROL);
    chk1(d[3], 1'b0);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_trig;
    wr(gtpc_pkg::ADDR_GATE_CONTROL, 8'h00);
    wr(gtpc_pkg::ADDR_COMPARE_LOW, 8'h20);
    wr(gtpc_pkg::ADDR_COMPARE_HIGH, 8'h00);
    wr(gtpc_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(gtpc_pkg::ADDR_ENABLES, 8'h02);
    compare_mode_field_in <= gtpc_pkg::COMPARE_SPECIAL;
    compare_unit_two_in <= 1'b1;
    adc_enabled_in <= 1'b1;
    wr(gtpc_pkg::ADDR_CONTROL, 8'h41);
    wait_adc;
    chk1(adc_start_out, 1'b1);
    wait_adc;
    chk(16'(n), 16'h0021);
    chk1(overflow_irq_out, 1'b0);
    @(posedge ref_clk_in);
    compare_mode_field_in <= 4'h0;
    wait_adc;
    chk1(count_out > 16'h0020, 1'b1);
    wr(gtpc_pkg::ADDR_CONTROL, 8'h00);
    wr(gtpc_pkg::ADDR_COUNT_HIGH, 8'h00);
    wr(gtpc_pkg::ADDR_COUNT_LOW, 8'h20);
    // trigger and count write are taken on the same edge
    @(posedge ref_clk_in);
    compare_unit_two_in <= 1'b0;
    compare_mode_field_in <= gtpc_pkg::COMPARE_SPECIAL;
    wr_in <= 1'b1;
    addr_in <= gtpc_pkg::ADDR_COUNT_LOW;
    wdata_in <= 8'h33;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    compare_mode_field_in <= 4'h0;
    @(negedge ref_clk_in);
    chk(count_out, 16'h0033);
  endtask
  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {nrst_in, wr_in, rd_in, run_period, gate_input_pin_in, comp1_in, comp2_in} = 7'h00;
    {ext_clk_in, compare_unit_two_in, adc_enabled_in} = 3'h0;
    clk_en_in = 1'b1;
    addr_in = 4'h0;
    compare_mode_field_in = 4'h0;
    wdata_in = 8'h00;
    mismatches = 0;
    checks_done = 0;
    cyc(10);
    nrst_in <= 1'b1;
    t_reset;
    t_wrap;
    t_clk;
    t_gate;
    t_pulse;
    t_trig;
    stop_test;
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    cyc(20000);
    mismatches++;
    stop_test;
  end
endmodule
